// ### shared/fsp_pkg.sv
// constants and types shared by the fan spin-up pwm block
package fsp_pkg;
    localparam int unsigned SYS_CLK_HZ     = 20_000_000;
    localparam int unsigned PWM_FAST_HZ    = 360_000;
    localparam int unsigned PWM_SLOW_HZ    = 1_400;
    // fast tick period rounded to nearest cycle: 20 MHz / 360 kHz is not whole
    localparam int unsigned PWM_FAST_DIV   = (SYS_CLK_HZ + PWM_FAST_HZ / 2) / PWM_FAST_HZ;
    localparam int unsigned PWM_SLOW_DIV   = (SYS_CLK_HZ + PWM_SLOW_HZ / 2) / PWM_SLOW_HZ;
    localparam int unsigned SPIN_BASE_US   = 50_000;
    localparam int unsigned SPIN_BASE_CYC  = (SYS_CLK_HZ / 1000) * SPIN_BASE_US / 1000;
    localparam int unsigned DIV_W          = 20;

    // spin-up configuration register layout
    localparam int unsigned CFG_W          = 8;
    localparam int unsigned CFG_TIME_LSB   = 0;
    localparam int unsigned CFG_TIME_W     = 3;
    localparam int unsigned CFG_DUTY_LSB   = 3;
    localparam int unsigned CFG_DUTY_W     = 2;
    localparam int unsigned CFG_FAST_BIT   = 5;
    localparam logic [7:0]  CFG_USED_MASK  = 8'h3F;
    localparam logic [7:0]  CFG_RESET      = 8'h00;

    localparam logic [1:0]  DUTY_SKIP      = 2'h0;
    localparam logic [1:0]  DUTY_HALF      = 2'h1;
    localparam logic [1:0]  DUTY_MID       = 2'h2;
    localparam logic [2:0]  TIME_SKIP      = 3'h0;

    localparam int unsigned FREQ_W         = 5;
    localparam int unsigned DUTY_W         = 6;
    localparam int unsigned UNIT_W         = 7;

    typedef logic [FREQ_W-1:0] fsp_freq_t;
    typedef logic [DUTY_W-1:0] fsp_duty_t;
    typedef enum logic {FSP_RUN, FSP_SPIN} fsp_state_t;
endpackage : fsp_pkg

// ### shared/fsp_pwm_if.sv
// carrier between the spin-up sequencer and the pwm counter
`timescale 1ns/1ps
`default_nettype none
interface fsp_pwm_if;
    import fsp_pkg::*;
    logic       tick;
    fsp_freq_t  half_period;
    fsp_duty_t  duty;
    logic       fan_on;
    modport ctl (output tick, output half_period, output duty, input fan_on);
    modport gen (input tick, input half_period, input duty, output fan_on);
endinterface : fsp_pwm_if
`default_nettype wire

// ### core/fsp_pwm_gen.sv
// pwm period counter: period is twice the frequency value in pwm clock ticks
`timescale 1ns/1ps
`default_nettype none
module fsp_pwm_gen (
    input  wire logic clk_sys,
    input  wire logic resetn,
    fsp_pwm_if.gen    pwm
);
    import fsp_pkg::*;

    fsp_duty_t cnt_r;
    fsp_duty_t cnt_nxt;
    logic      on_r;
    logic      on_nxt;
    fsp_duty_t period;

    always_comb begin
        period  = {pwm.half_period, 1'b0};
        cnt_nxt = cnt_r;
        if (pwm.tick) begin
            if (cnt_r >= period - 6'h01)
                cnt_nxt = 6'h00;
            else
                cnt_nxt = cnt_r + 6'h01;
        end
        // zero frequency value: no period exists, so any nonzero duty is full on
        if (period == 6'h00)
            on_nxt = (pwm.duty != 6'h00);
        else
            on_nxt = (cnt_r < pwm.duty);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 6'h00;
            on_r  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            on_r  <= on_nxt;
        end
    end

    assign pwm.fan_on = on_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_period_wrap: assert property (pwm.tick && pwm.half_period != 5'h00 && $stable(pwm.half_period) && cnt_r == {pwm.half_period, 1'b0} - 6'h01 |=> cnt_r == 6'h00) else $error("pwm counter did not wrap at end of period");
    a_duty_compare: assert property (pwm.half_period != 5'h00 |=> on_r == ($past(cnt_r) < $past(pwm.duty))) else $error("pwm level disagrees with duty compare");
endmodule : fsp_pwm_gen
`default_nettype wire

// ### core/fsp_spinup_top.sv
// fan spin-up sequencer driving an open-drain pwm fan output
// Summary of operation
// - upper two config bits read zero and ignore writes
// - fast bit clear: spin-up uses programmed duty code and time code
// - fast bit set: full duty until time expires or, in tach mode, tach reaches setpoint
// - fast bit set overrides the duty code; spin-up output is full duty at any nonzero frequency value, off at frequency value zero
// - time code zero skips spin-up regardless of the fast bit
// - duty code zero skips spin-up unless the fast bit is set
// - duty codes: 01 half, 10 about three quarters, 11 full
// - pwm frequency is selected pwm clock over twice frequency value
// - polarity selects whether fan off pulls low or releases the pin
`timescale 1ns/1ps
`default_nettype none
module fsp_spinup_top #(
    parameter int unsigned SPIN_BASE_CYCLES = fsp_pkg::SPIN_BASE_CYC,
    parameter int unsigned PWM_SLOW_CYCLES  = fsp_pkg::PWM_SLOW_DIV
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             cfg_wr_en,
    input  wire logic [7:0]       cfg_wr_data,
    output logic      [7:0]       cfg_rd_data,
    input  wire fsp_pkg::fsp_freq_t pwm_freq,
    input  wire logic             pwm_clk_slow,
    input  wire logic             pwm_pol,
    input  wire fsp_pkg::fsp_duty_t normal_duty,
    input  wire logic             tach_mode_en,
    input  wire logic             tach_at_min,
    output logic                  spin_active,
    output logic                  pwm_o,
    output logic                  pwm_oe
);
    import fsp_pkg::*;

    fsp_pwm_if pwm_bus ();

    logic [7:0]       cfg_r;
    logic [7:0]       cfg_nxt;
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;
    logic [DIV_W-1:0] div_top;
    logic             tick;
    fsp_state_t       state_r;
    fsp_state_t       state_nxt;
    logic [DIV_W-1:0] base_r;
    logic [DIV_W-1:0] base_nxt;
    logic [UNIT_W-1:0] unit_r;
    logic [UNIT_W-1:0] unit_nxt;
    logic             was_off_r;
    logic             was_off_nxt;
    logic             oe_r;
    logic             oe_nxt;
    logic [2:0]       time_code;
    logic [1:0]       duty_code;
    logic             fast;
    logic             start_evt;
    logic             skip;
    logic [UNIT_W-1:0] unit_target;
    logic             time_done;
    logic             tach_done;
    fsp_duty_t        full_duty;
    fsp_duty_t        spin_duty;
    fsp_duty_t        duty_sel;

    assign time_code = cfg_r[CFG_TIME_LSB +: CFG_TIME_W];
    assign duty_code = cfg_r[CFG_DUTY_LSB +: CFG_DUTY_W];
    assign fast      = cfg_r[CFG_FAST_BIT];

    // config register
    always_comb begin
        cfg_nxt = cfg_r;
        if (cfg_wr_en)
            cfg_nxt = cfg_wr_data & CFG_USED_MASK;
    end
    assign cfg_rd_data = cfg_r;

    // pwm clock tick from the system clock
    always_comb begin
        div_top = pwm_clk_slow ? DIV_W'(PWM_SLOW_CYCLES - 1) : DIV_W'(PWM_FAST_DIV - 1);
        tick    = (div_r >= div_top);
        div_nxt = tick ? '0 : div_r + 1'b1;
    end

    // spin-up duty and time decoding
    always_comb begin
        full_duty = {pwm_freq, 1'b0};
        if (fast)
            spin_duty = full_duty;
        else begin
            case (duty_code)
                DUTY_HALF: spin_duty = {1'b0, pwm_freq};
                // three quarters rounded up; lands in the 75-100% band for small values
                DUTY_MID:  spin_duty = {1'b0, pwm_freq} + ((DUTY_W'(pwm_freq) + 6'h01) >> 1);
                default:   spin_duty = full_duty;
            endcase
        end
        unit_target = UNIT_W'(1) << (time_code - 3'h1);
    end

    assign start_evt = was_off_r && (normal_duty != 6'h00);
    // skipped when no time, or when no duty without the fast override
    assign skip      = (time_code == TIME_SKIP)
                     || (!fast && duty_code == DUTY_SKIP);
    assign time_done = (base_r >= DIV_W'(SPIN_BASE_CYCLES - 1)) && (unit_r + 1'b1 >= unit_target);
    // tach only terminates when the shared pin is in tach mode
    assign tach_done = fast && tach_mode_en && tach_at_min;

    // sequencer
    always_comb begin
        state_nxt   = state_r;
        base_nxt    = base_r;
        unit_nxt    = unit_r;
        was_off_nxt = (normal_duty == 6'h00);
        case (state_r)
            FSP_RUN: begin
                base_nxt = '0;
                unit_nxt = '0;
                if (start_evt && !skip)
                    state_nxt = FSP_SPIN;
            end
            FSP_SPIN: begin
                if (normal_duty == 6'h00 || time_done || tach_done)
                    state_nxt = FSP_RUN;
                if (base_r >= DIV_W'(SPIN_BASE_CYCLES - 1)) begin
                    base_nxt = '0;
                    unit_nxt = unit_r + 1'b1;
                end else
                    base_nxt = base_r + 1'b1;
                // clear the timer on exit so a later spin-up always starts from zero
                if (state_nxt == FSP_RUN) begin
                    base_nxt = '0;
                    unit_nxt = '0;
                end
            end
            default: state_nxt = FSP_RUN;
        endcase
    end

    // duty handed to the pwm counter
    always_comb begin
        duty_sel = (state_r == FSP_SPIN) ? spin_duty : normal_duty;
    end

    assign pwm_bus.tick        = tick;
    assign pwm_bus.half_period = pwm_freq;
    assign pwm_bus.duty        = duty_sel;

    fsp_pwm_gen u_gen (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pwm     (pwm_bus)
    );

    // open-drain: pin is only ever pulled low, so enabled means 0 V
    always_comb begin
        oe_nxt = pwm_pol ? pwm_bus.fan_on : !pwm_bus.fan_on;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_r     <= CFG_RESET;
            div_r     <= '0;
            state_r   <= FSP_RUN;
            base_r    <= '0;
            unit_r    <= '0;
            was_off_r <= 1'b1;
            oe_r      <= 1'b0;
        end else begin
            cfg_r     <= cfg_nxt;
            div_r     <= div_nxt;
            state_r   <= state_nxt;
            base_r    <= base_nxt;
            unit_r    <= unit_nxt;
            was_off_r <= was_off_nxt;
            oe_r      <= oe_nxt;
        end
    end

    assign pwm_o       = 1'b0;
    assign pwm_oe      = oe_r;
    assign spin_active = (state_r == FSP_SPIN);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_upper_zero: assert property (cfg_wr_en |=> cfg_rd_data[7:6] == 2'h0 && cfg_rd_data[5:0] == $past(cfg_wr_data[5:0])) else $error("config write not masked to low six bits");
    a_start_spin: assert property (state_r == FSP_RUN && start_evt && !skip |=> state_r == FSP_SPIN) else $error("spin-up did not start");
    a_tach_end: assert property (state_r == FSP_SPIN && fast && tach_mode_en && tach_at_min |=> state_r == FSP_RUN) else $error("tach setpoint did not end spin-up");
    a_fast_full: assert property (state_r == FSP_SPIN && fast |-> pwm_bus.duty == {pwm_freq, 1'b0}) else $error("fast spin-up not at full duty");
    a_tach_ignored: assert property (state_r == FSP_SPIN && !tach_mode_en && !time_done && normal_duty != 6'h00 |=> state_r == FSP_SPIN) else $error("tach ended spin-up outside tach mode");
    a_skip_time: assert property (state_r == FSP_RUN && time_code == 3'h0 |=> state_r == FSP_RUN) else $error("spin-up ran with zero time");
    a_skip_duty: assert property (state_r == FSP_RUN && !fast && duty_code == 2'h0 |=> state_r == FSP_RUN) else $error("spin-up ran with zero duty");
    a_half_duty: assert property (state_r == FSP_SPIN && !fast && duty_code == 2'h1 |-> pwm_bus.duty == {1'b0, pwm_freq}) else $error("half duty code wrong");
    a_time_expiry: assert property (state_r == FSP_SPIN && time_done |=> state_r == FSP_RUN && unit_r == 7'h00) else $error("spin-up outlived its time");
    a_od_polarity: assert property (1'b1 |=> pwm_oe == ($past(pwm_pol) ? $past(pwm_bus.fan_on) : !$past(pwm_bus.fan_on))) else $error("open-drain polarity wrong");
    a_return_normal: assert property (state_r == FSP_RUN |-> pwm_bus.duty == normal_duty) else $error("normal duty not restored");
endmodule : fsp_spinup_top
`default_nettype wire

// ### verification/fsp_fan_model.sv
// behavioural fan on the open-drain pwm pin, with tach speed feedback
`timescale 1ns/1ps
`default_nettype none
module fsp_fan_model #(
    parameter int SPIN_NEED = 100
) (
    input  wire logic clk_sys,
    input  wire logic pwm_o,
    input  wire logic pwm_oe,
    input  wire logic pwm_pol,
    input  wire logic fan_stall,
    output logic      fan_on,
    output logic      tach_at_min
);
    logic pin;
    int   on_cnt = 0;
    // pull-up: a released pin reads high, never the last driven value
    assign pin    = pwm_oe ? pwm_o : 1'b1;
    assign fan_on = pwm_pol ? ~pin : pin;
    // rotor needs SPIN_NEED driven cycles to reach the setpoint; a stall loses it
    always_ff @(posedge clk_sys) begin
        if (fan_stall) begin
            on_cnt <= 0;
        end else if (fan_on === 1'b1) begin
            on_cnt <= on_cnt + 1;
        end
    end
    assign tach_at_min = on_cnt >= SPIN_NEED;
endmodule : fsp_fan_model
`default_nettype wire

// ### verification/tb_fan_spinup_pwm_control.sv
// self-checking bench for the fan spin-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_fan_spinup_pwm_control;
    import fsp_pkg::*;
    localparam int BASE = 20;
    localparam int SLOW = 10;
    logic       clk_sys, resetn, cfg_wr_en, pwm_clk_slow, pwm_pol, tach_mode_en, fan_stall;
    logic [7:0] cfg_wr_data, cfg_rd_data;
    fsp_freq_t  pwm_freq;
    fsp_duty_t  normal_duty;
    logic       tach_at_min, spin_active, pwm_o, pwm_oe, fan_on;
    int         error_cnt = 0;
    int         cmp_count = 0;

    fsp_spinup_top #(.SPIN_BASE_CYCLES(BASE), .PWM_SLOW_CYCLES(SLOW)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .cfg_wr_en(cfg_wr_en),
        .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .pwm_freq(pwm_freq),
        .pwm_clk_slow(pwm_clk_slow), .pwm_pol(pwm_pol), .normal_duty(normal_duty),
        .tach_mode_en(tach_mode_en), .tach_at_min(tach_at_min),
        .spin_active(spin_active), .pwm_o(pwm_o), .pwm_oe(pwm_oe));
    fsp_fan_model #(.SPIN_NEED(100)) fan (.clk_sys(clk_sys), .pwm_o(pwm_o),
        .pwm_oe(pwm_oe), .pwm_pol(pwm_pol), .fan_stall(fan_stall), .fan_on(fan_on),
        .tach_at_min(tach_at_min));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr_cfg(input logic [7:0] v);
        @(posedge clk_sys);
        cfg_wr_en   <= 1'b1;
        cfg_wr_data <= v;
        @(posedge clk_sys);
        cfg_wr_en   <= 1'b0;
    endtask : wr_cfg

    task automatic start(input logic [7:0] cfg, input fsp_duty_t nd);
        wr_cfg(cfg);
        @(posedge clk_sys);
        normal_duty <= nd;
    endtask : start

    // fan stopped and tach lost so every spin-up begins from rest
    task automatic stop();
        @(posedge clk_sys);
        normal_duty <= 6'h00;
        fan_stall   <= 1'b1;
        repeat (3) @(posedge clk_sys);
        fan_stall   <= 1'b0;
    endtask : stop

    task automatic wait_len(output int len);
        len = 0;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk_sys);
            if (spin_active === 1'b1) begin
                len++;
            end else if (len > 0 || i > 10) begin
                return;
            end
        end
        error_cnt++;
        $display("unexpected at %0t: spin-up never ended", $time);
        report_and_stop();
    endtask : wait_len

    task automatic count_on(input int n, output int on);
        on = 0;
        repeat (n) begin
            @(negedge clk_sys);
            on += int'(fan_on === 1'b1);
        end
    endtask : count_on

    task automatic t_time();
        int len;
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 8; k++) begin
                start({2'b00, f[0], 2'b01, k[2:0]}, 6'h01);
                wait_len(len);
                check(len, k == 0 ? 0 : BASE << (k - 1));
                stop();
            end
        end
        $display("time code test done");
    endtask : t_time

    task automatic t_skip_tach();
        int len;
        start(8'h01, 6'h01);
        wait_len(len);
        check(len, 0);
        stop();
        start(8'h21, 6'h01);
        wait_len(len);
        check(len, BASE);
        stop();
        tach_mode_en <= 1'b1;
        start(8'h27, 6'h01);
        wait_len(len);
        check(len >= 100 && len <= 106, 1);
        stop();
        tach_mode_en <= 1'b0;
        $display("skip and tach test done");
    endtask : t_skip_tach

    // windows span four whole pwm periods (16 ticks) so the on count is phase free
    task automatic t_duty(input logic slow, input logic pol, input logic [7:0] cfg, input int d);
        int tick, on, len;
        tick = slow ? SLOW : int'(PWM_FAST_DIV);
        @(posedge clk_sys);
        pwm_clk_slow <= slow;
        pwm_pol      <= pol;
        start(cfg, 6'h01);
        repeat (60) @(negedge clk_sys);
        count_on(16 * tick, on);
        check(on, 4 * d * tick);
        wait_len(len);
        repeat (4) @(negedge clk_sys);
        count_on(16 * tick, on);
        check(on, 4 * tick);
        stop();
        $display("duty test cfg %0h pol %0b done", cfg, pol);
    endtask : t_duty

    initial begin
        resetn       = 1'b0;
        cfg_wr_en    = 1'b0;
        cfg_wr_data  = 8'h00;
        pwm_freq     = 5'h02;
        pwm_clk_slow = 1'b1;
        pwm_pol      = 1'b0;
        normal_duty  = 6'h00;
        tach_mode_en = 1'b0;
        fan_stall    = 1'b1;
        repeat (4) @(posedge clk_sys);
        check(cfg_rd_data, 8'h00);
        check(pwm_oe, 1'b0);
        resetn    <= 1'b1;
        fan_stall <= 1'b0;
        wr_cfg(8'hFF);
        @(negedge clk_sys);
        check(cfg_rd_data, 8'h3F);
        wr_cfg(8'h2B);
        @(negedge clk_sys);
        check(cfg_rd_data, 8'h2B);
        t_time();
        t_skip_tach();
        for (int p = 0; p < 2; p++) begin
            for (int c = 1; c < 4; c++) begin
                t_duty(1'b1, p[0], {3'b000, c[1:0], 3'h7}, c == 1 ? 2 : c == 2 ? 3 : 4);
            end
            t_duty(1'b1, p[0], 8'h2F, 4);
        end
        t_duty(1'b0, 1'b0, 8'h0F, 2);
        report_and_stop();
    end
endmodule : tb_fan_spinup_pwm_control
`default_nettype wire
